// File: shared/adc_seq_pkg.sv
// Package: register offsets, field positions, reset values and timing constants for the converter sequencer
package adc_seq_pkg;

  // Register byte addresses (one aligned 32-bit word each)
  localparam logic [7:0] MAIN_CONTROL_ADDR       = 8'h00;
  localparam logic [7:0] FORMAT_REF_CONTROL_ADDR = 8'h9C;
  localparam logic [7:0] RESULT_HIGH_ADDR        = 8'hA0;
  localparam logic [7:0] RESULT_LOW_ADDR         = 8'hA4;
  localparam logic [7:0] SAMPLE_ADDR             = 8'hA8;
  localparam logic [7:0] STATUS_ADDR             = 8'hAC;
  // Printed index of the format/reference register, kept for reference
  localparam logic [7:0] FORMAT_REF_INDEX        = 8'h9F;

  // Main control field positions
  localparam int CLK_SEL_MSB  = 7;
  localparam int CLK_SEL_LSB  = 6;
  localparam int CHAN_MSB     = 5;
  localparam int CHAN_LSB     = 3;
  localparam int START_BIT    = 2;
  localparam int ENABLE_BIT   = 0;

  // Format/reference field positions
  localparam int FORMAT_BIT   = 7;
  localparam int HALVE_BIT    = 6;
  localparam int REF_MSB      = 5;
  localparam int REF_LSB      = 4;

  // Status register bit positions
  localparam int IRQ_FLAG_BIT = 0;
  localparam int HOLD_OFF_BIT = 1;

  // Reset values
  localparam logic [7:0] MAIN_CONTROL_RESET = 8'h00;
  localparam logic [7:0] FORMAT_REF_RESET   = 8'h00;

  // Clock-select encodings
  localparam logic [1:0] CLK_SEL_RC = 2'h3;

  // Timing: bit periods per conversion and after it
  localparam int CONV_BIT_PERIODS = 9;
  localparam int HOLD_BIT_PERIODS = 2;
  localparam int RESULT_BITS      = 10;

endpackage

// File: core/adc_sequencer_control.sv
// Converter sequencer: Wishbone register file, bit-period clock divider and conversion sequencing
`timescale 1ns/100ps
`default_nettype none

// Overview of operation
// - Completion loads result, clears start, sets flag
// - Start bit reads one during conversion
// - Format bit selects right or left justification
// - Halving bit doubles system-derived bit period
// - Two-bit field selects reference pair
// - Unimplemented control bits read zero
// - Capacitor disconnected two bit periods after
// - Capacitor never discharged after conversion
// - Conversion takes nine bit periods
// - Seven bit-period sources selectable
// - Clock-select field picks conversion clock
module adc_sequencer_control #(
  parameter int RC_DIV = 80   // System clocks per internal RC bit period (4 us at 20 MHz)
) (
  // Clock and reset
  input  wire  logic        clk,
  input  wire  logic        rst,
  // Wishbone classic slave
  input  wire  logic        wb_cyc_i,
  input  wire  logic        wb_stb_i,
  input  wire  logic        wb_we_i,
  input  wire  logic [7:0]  wb_adr_i,
  input  wire  logic [3:0]  wb_sel_i,
  input  wire  logic [31:0] wb_dat_i,
  output var   logic [31:0] wb_dat_o,
  output var   logic        wb_ack_o,
  // Analog front end
  input  wire  logic [9:0]  sar_result,
  output var   logic        converter_power,
  output var   logic [2:0]  channel_select,
  output var   logic [1:0]  reference_config,
  output var   logic        sample_connect,
  output var   logic        sar_active,
  // Completion flag
  output var   logic        converter_irq_flag
);

  //////////////////////////////////////////////////////////////////////////////
  // Elaboration checks

  // The divider counts in 12 bits, so the RC period must fit below 4096
  if (RC_DIV < 2 || RC_DIV > 4095) begin : gen_bad_rc_div
    $error("RC_DIV out of range");
  end

  //////////////////////////////////////////////////////////////////////////////
  // Sequencer state

  typedef enum logic [2:0] {
    ST_IDLE    = 3'b001,
    ST_CONVERT = 3'b010,
    ST_HOLD    = 3'b100
  } seq_state_e;

  seq_state_e  state;
  logic [7:0]  adc_main_control;
  logic [7:0]  adc_format_reference_control;
  logic [7:0]  result_high_byte;
  logic [7:0]  result_low_byte;
  logic [11:0] div_count;
  logic [11:0] div_limit;
  logic        bit_tick;
  logic [3:0]  tick_count;
  logic        wr_main;
  logic        wr_format;
  logic        wr_high;
  logic        wr_low;
  logic        wr_status;
  logic        bus_req;
  logic        conv_done;
  logic        start_req;
  logic [15:0] justified;

  // New request only while ack is low: one ack per classic cycle
  assign bus_req   = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr_main   = bus_req && wb_we_i && wb_sel_i[0] && (wb_adr_i == adc_seq_pkg::MAIN_CONTROL_ADDR);
  assign wr_format = bus_req && wb_we_i && wb_sel_i[0] && (wb_adr_i == adc_seq_pkg::FORMAT_REF_CONTROL_ADDR);
  assign wr_high   = bus_req && wb_we_i && wb_sel_i[0] && (wb_adr_i == adc_seq_pkg::RESULT_HIGH_ADDR);
  assign wr_low    = bus_req && wb_we_i && wb_sel_i[0] && (wb_adr_i == adc_seq_pkg::RESULT_LOW_ADDR);
  assign wr_status = bus_req && wb_we_i && wb_sel_i[0] && (wb_adr_i == adc_seq_pkg::STATUS_ADDR);

  // Start is honoured only from idle with the module powered
  // enable gates start
  assign start_req = wr_main && wb_dat_i[adc_seq_pkg::START_BIT] && wb_dat_i[adc_seq_pkg::ENABLE_BIT]
                     && (state == ST_IDLE);

  // Final bit period of a conversion
  // nine bit periods
  assign conv_done = (state == ST_CONVERT) && bit_tick
                     && (tick_count == 4'(adc_seq_pkg::CONV_BIT_PERIODS - 1));

  //////////////////////////////////////////////////////////////////////////////
  // Bit-period divider

  // System clocks per bit period from the clock fields
  // clock select decode
  always_comb begin
    case (adc_main_control[adc_seq_pkg::CLK_SEL_MSB:adc_seq_pkg::CLK_SEL_LSB])
      2'h0:    div_limit = 12'h002;
      2'h1:    div_limit = 12'h008;
      2'h2:    div_limit = 12'h020;
      default: div_limit = 12'(RC_DIV);
    endcase
    if (adc_format_reference_control[adc_seq_pkg::HALVE_BIT]
        && adc_main_control[adc_seq_pkg::CLK_SEL_MSB:adc_seq_pkg::CLK_SEL_LSB] != adc_seq_pkg::CLK_SEL_RC) begin
      div_limit = {div_limit[10:0], 1'b0};
    end
  end

  // Free-running only while sequencing so each conversion starts on a fresh period;
  // the start edge already counts as the first clock, keeping a conversion at exactly nine periods
  always_ff @(posedge clk) begin
    if (rst || (state == ST_IDLE && !start_req)) begin
      div_count <= 12'h000;
      bit_tick  <= 1'b0;
    end else if (div_count == div_limit - 12'h001) begin
      div_count <= 12'h000;
      bit_tick  <= 1'b1;
    end else begin
      div_count <= div_count + 12'h001;
      bit_tick  <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Sequencer

  // Software clearing the start bit is not modelled as an abort here
  // two-period hold-off
  always_ff @(posedge clk) begin
    if (rst) begin
      state      <= ST_IDLE;
      tick_count <= 4'h0;
    end else begin
      case (state)
        ST_IDLE: begin
          tick_count <= 4'h0;
          if (start_req) begin
            state <= ST_CONVERT;
          end
        end
        ST_CONVERT: begin
          if (conv_done) begin
            state      <= ST_HOLD;
            tick_count <= 4'h0;
          end else if (bit_tick) begin
            tick_count <= tick_count + 4'h1;
          end
        end
        ST_HOLD: begin
          if (bit_tick && tick_count == 4'(adc_seq_pkg::HOLD_BIT_PERIODS - 1)) begin
            state      <= ST_IDLE;
            tick_count <= 4'h0;
          end else if (bit_tick) begin
            tick_count <= tick_count + 4'h1;
          end
        end
        default: begin
          state      <= ST_IDLE;
          tick_count <= 4'h0;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Registers

  // Main control; start bit held by hardware until completion
  // start reads one
  always_ff @(posedge clk) begin
    if (rst) begin
      adc_main_control <= adc_seq_pkg::MAIN_CONTROL_RESET;
    end else begin
      if (wr_main) begin
        adc_main_control[7:3] <= wb_dat_i[7:3];
        adc_main_control[adc_seq_pkg::ENABLE_BIT] <= wb_dat_i[adc_seq_pkg::ENABLE_BIT];
      end
      if (conv_done) begin
        adc_main_control[adc_seq_pkg::START_BIT] <= 1'b0;
      end else if (start_req) begin
        adc_main_control[adc_seq_pkg::START_BIT] <= 1'b1;
      end
      adc_main_control[1] <= 1'b0;
    end
  end

  // Format/reference control, low nibble unimplemented
  // low bits zero
  always_ff @(posedge clk) begin
    if (rst) begin
      adc_format_reference_control <= adc_seq_pkg::FORMAT_REF_RESET;
    end else if (wr_format) begin
      adc_format_reference_control <= {wb_dat_i[7:4], 4'h0};
    end
  end

  // Justification at load time; extra bits are zeros
  // justify result
  assign justified = adc_format_reference_control[adc_seq_pkg::FORMAT_BIT]
                     ? {6'h00, sar_result}
                     : {sar_result, 6'h00};

  // Result pair: completion wins over a software write in the same cycle
  // load result
  always_ff @(posedge clk) begin
    if (rst) begin
      result_high_byte <= 8'h00;
      result_low_byte  <= 8'h00;
    end else if (conv_done) begin
      result_high_byte <= justified[15:8];
      result_low_byte  <= justified[7:0];
    end else begin
      if (wr_high) begin
        result_high_byte <= wb_dat_i[7:0];
      end
      if (wr_low) begin
        result_low_byte <= wb_dat_i[7:0];
      end
    end
  end

  // Completion flag: set wins over software clear; reading does not clear
  // set flag
  always_ff @(posedge clk) begin
    if (rst) begin
      converter_irq_flag <= 1'b0;
    end else if (conv_done) begin
      converter_irq_flag <= 1'b1;
    end else if (wr_status && !wb_dat_i[adc_seq_pkg::IRQ_FLAG_BIT]) begin
      converter_irq_flag <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Analog front-end controls

  // Sample switch closed only when powered and idle; no discharge path exists,
  // so the held charge carries into the next acquisition
  // disconnect during hold
  always_ff @(posedge clk) begin
    if (rst) begin
      converter_power  <= 1'b0;
      channel_select   <= 3'h0;
      reference_config <= 2'h0;
      sample_connect   <= 1'b0;
      sar_active       <= 1'b0;
    end else begin
      // Follow the enable as it is written, so a start written with it is never unpowered
      converter_power  <= wr_main ? wb_dat_i[adc_seq_pkg::ENABLE_BIT] : adc_main_control[adc_seq_pkg::ENABLE_BIT];
      channel_select   <= adc_main_control[adc_seq_pkg::CHAN_MSB:adc_seq_pkg::CHAN_LSB];
      reference_config <= adc_format_reference_control[adc_seq_pkg::REF_MSB:adc_seq_pkg::REF_LSB];
      sample_connect   <= adc_main_control[adc_seq_pkg::ENABLE_BIT] && (state == ST_IDLE) && !start_req;
      sar_active       <= (state == ST_CONVERT) && !conv_done || start_req;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Wishbone read and acknowledge

  // One-cycle answer; unmapped addresses ack with zero data
  always_ff @(posedge clk) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= bus_req;
      wb_dat_o <= 32'h0000_0000;
      if (bus_req && !wb_we_i) begin
        case (wb_adr_i)
          adc_seq_pkg::MAIN_CONTROL_ADDR:       wb_dat_o <= {24'h000000, adc_main_control};
          adc_seq_pkg::FORMAT_REF_CONTROL_ADDR: wb_dat_o <= {24'h000000, adc_format_reference_control};
          adc_seq_pkg::RESULT_HIGH_ADDR:        wb_dat_o <= {24'h000000, result_high_byte};
          adc_seq_pkg::RESULT_LOW_ADDR:         wb_dat_o <= {24'h000000, result_low_byte};
          adc_seq_pkg::SAMPLE_ADDR:             wb_dat_o <= {24'h000000, {5'h00, state}};
          adc_seq_pkg::STATUS_ADDR:             wb_dat_o <= {30'h00000000, (state == ST_HOLD),
                                                             converter_irq_flag};
          default:                              wb_dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end

endmodule

`default_nettype wire

// File: dv/adc_sequencer_control_assertions.sv
// Checker for the converter sequencer ports
`timescale 1ns/100ps
`default_nettype none
module adc_sequencer_control_assertions #(
  parameter int RC_DIV = 80
) (
  // Clock and reset
  input wire logic        clk,
  input wire logic        rst,
  // Register bus
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  // Analog side
  input wire logic [9:0]  sar_result,
  input wire logic        converter_power,
  input wire logic [2:0]  channel_select,
  input wire logic [1:0]  reference_config,
  input wire logic        sample_connect,
  input wire logic        sar_active,
  input wire logic        converter_irq_flag
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Bus answers one cycle after a taken request
  AST_ACK_NEXT: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing after request");
  AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  AST_DAT_UPPER: assert property (wb_dat_o[31:8] == 24'h0)
    else $error("upper read data not zero");
  AST_FLAG_SET: assert property ($fell(sar_active) |-> converter_irq_flag)
    else $error("flag not set at completion");
  AST_FLAG_CAUSE: assert property ($rose(converter_irq_flag) |-> $fell(sar_active))
    else $error("flag set outside completion");
  AST_HOLD_OFF: assert property ($fell(sar_active) |-> (!sample_connect) [*4])
    else $error("capacitor reconnected too early");
  AST_ISOLATE: assert property (sar_active |-> !sample_connect)
    else $error("capacitor connected while converting");
  AST_CONV_MIN: assert property ($rose(sar_active) |-> sar_active [*8])
    else $error("conversion ended too soon");
  AST_POWER: assert property ($rose(sar_active) |-> converter_power)
    else $error("conversion without power");
endmodule
`default_nettype wire

// File: dv/adc_front_model.sv
// Analog front-end stand-in driving the converter result
`timescale 1ns/100ps
`default_nettype none
module adc_front_model (
  // Sequencer side
  input  wire logic       sar_active,
  input  wire logic [9:0] level,
  // Result to sequencer
  output var  logic [9:0] sar_result
);
  // Outside a conversion show the inverse, so early or late sampling is caught
  assign sar_result = sar_active ? level : ~level;
endmodule
`default_nettype wire

// File: dv/tb.sv
// Testbench for the converter sequencer
`timescale 1ns/100ps
`default_nettype none
module tb;
  localparam int RC = 6;
  localparam int ACQ = 400; // Acquisition wait in clocks, about 20 us
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        wb_cyc_i = 1'b0;
  logic        wb_stb_i = 1'b0;
  logic        wb_we_i = 1'b0;
  logic [7:0]  wb_adr_i = 8'h00;
  logic [3:0]  wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic [9:0]  sar_result;
  logic [9:0]  level = 10'h000;
  logic        converter_power, sample_connect, sar_active, converter_irq_flag;
  logic [2:0]  channel_select, c;
  logic [1:0]  reference_config;
  logic [7:0]  q, hi, lo;
  logic        clr = 1'b0;
  int          error_cnt = 0, num_checks = 0, act_cnt = 0, hold_cnt = 0, n;
  int          divs[8] = '{2, 8, 32, RC, 4, 16, 64, RC};
  adc_sequencer_control #(.RC_DIV(RC)) adc_sequencer_control_inst (.clk(clk), .rst(rst), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .sar_result(sar_result), .converter_power(converter_power),
    .channel_select(channel_select), .reference_config(reference_config), .sample_connect(sample_connect),
    .sar_active(sar_active), .converter_irq_flag(converter_irq_flag));
  adc_front_model adc_front_model_inst (.sar_active(sar_active), .level(level), .sar_result(sar_result));
  initial begin
    forever #25 clk = ~clk;
  end
  // Conversion and hold-off lengths in clocks; the flag marks the hold-off after completion
  always @(posedge clk) begin
    act_cnt <= clr ? 0 : act_cnt + (sar_active === 1'b1);
    hold_cnt <= clr ? 0 : hold_cnt + (converter_irq_flag === 1'b1 && sample_connect === 1'b0 && !sar_active);
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Classic single cycle: hold everything until ack is sampled
  task automatic bus(input logic we, input logic [7:0] a, input logic [7:0] d, output logic [7:0] r);
    @(posedge clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= {24'h0, d};
    do @(posedge clk); while (wb_ack_o !== 1'b1);
    r = wb_dat_o[7:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task automatic complete_run;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    #2000000;
    error_cnt++;
    complete_run;
  end
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    bus(0, adc_seq_pkg::MAIN_CONTROL_ADDR, 8'h00, q);
    check(q, 8'h00); // main reset value
    bus(0, adc_seq_pkg::FORMAT_REF_CONTROL_ADDR, 8'h00, q);
    check(q, 8'h00); // format reset value
    // Unmapped place ignores writes and reads zero
    bus(1, 8'h50, 8'hFF, q);
    bus(0, 8'h50, 8'h00, q);
    check(q, 8'h00);
    bus(1, adc_seq_pkg::FORMAT_REF_CONTROL_ADDR, 8'hFF, q);
    bus(0, adc_seq_pkg::FORMAT_REF_CONTROL_ADDR, 8'h00, q);
    check(q, 8'hF0); // low bits zero
    // reference and input pins are set analog outside this block
    for (n = 0; n < 4; n++) begin
      bus(1, adc_seq_pkg::FORMAT_REF_CONTROL_ADDR, {2'b00, n[1:0], 4'h0}, q);
      // Registered copy settles one clock after the write
      @(negedge clk);
      check(reference_config, n[1:0]); // reference pairs
    end
    // Start with the converter off must be ignored
    bus(1, adc_seq_pkg::MAIN_CONTROL_ADDR, 8'hFE, q);
    bus(0, adc_seq_pkg::MAIN_CONTROL_ADDR, 8'h00, q);
    check(q, 8'hF8); // bit one zero, no start
    check({channel_select, sar_active, converter_power}, {3'h7, 2'b00});
    // Every conversion clock source, both justifications
    for (n = 0; n < 8; n++) begin
      c = n[2:0];
      level <= 10'h2A5 ^ 10'(n);
      clr <= 1'b1;
      bus(1, adc_seq_pkg::FORMAT_REF_CONTROL_ADDR, {c[0], c[2], 6'h0}, q);
      clr <= 1'b0;
      // references first, then clock and channel with the module on
      bus(1, adc_seq_pkg::MAIN_CONTROL_ADDR, {c[1:0], c, 3'b001}, q);
      // acquisition time before the start bit
      repeat (ACQ) @(posedge clk);
      bus(1, adc_seq_pkg::MAIN_CONTROL_ADDR, {c[1:0], c, 3'b101}, q);
      bus(0, adc_seq_pkg::MAIN_CONTROL_ADDR, 8'h00, q);
      check(q[2], 1'b1); // busy while converting
      check({channel_select, converter_power}, {c, 1'b1});
      // next start only after the hold-off has ended
      for (int w = 0; w < 3000 && sample_connect !== 1'b1; w++) @(posedge clk);
      check(16'(act_cnt), 16'(9 * divs[n])); // nine bit periods
      // The registered switch closes one clock after the sequencer is idle again
      check(16'(hold_cnt), 16'(2 * divs[n] + 1)); // two bit periods hold-off
      bus(0, adc_seq_pkg::RESULT_HIGH_ADDR, 8'h00, hi);
      bus(0, adc_seq_pkg::RESULT_LOW_ADDR, 8'h00, lo);
      check({hi, lo}, c[0] ? {6'h0, level} : {level, 6'h0}); // result and justification
      bus(0, adc_seq_pkg::STATUS_ADDR, 8'h00, q);
      check(q[0], 1'b1); // flag set
      bus(0, adc_seq_pkg::MAIN_CONTROL_ADDR, 8'h00, q);
      check(q[2], 1'b0); // start cleared
      bus(1, adc_seq_pkg::STATUS_ADDR, 8'h00, q); // clear flag after reading result
      check(converter_irq_flag, 1'b0); // flag cleared by software only
    end
    complete_run;
  end
endmodule
bind adc_sequencer_control adc_sequencer_control_assertions #(.RC_DIV(RC_DIV)) chk_inst (.clk(clk), .rst(rst),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
  .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .sar_result(sar_result),
  .converter_power(converter_power), .channel_select(channel_select), .reference_config(reference_config),
  .sample_connect(sample_connect), .sar_active(sar_active), .converter_irq_flag(converter_irq_flag));
`default_nettype wire
